// ---- fcl_map.svh ----
`ifndef FCL_MAP_SVH
`define FCL_MAP_SVH

// Register addresses
`define FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY        8'h64
`define FCL_ADDR_PWM2_MIN_DUTY        8'h65
`define FCL_ADDR_PWM3_MIN_DUTY        8'h66
`define FCL_ADDR_REMOTE1_START_TEMP   8'h67
`define FCL_ADDR_LOCAL_START_TEMP     8'h68
`define FCL_ADDR_REMOTE2_START_TEMP   8'h69
`define FCL_ADDR_REMOTE1_CRIT_LIMIT   8'h6A
`define FCL_ADDR_LOCAL_CRIT_LIMIT     8'h6B
`define FCL_ADDR_REMOTE2_CRIT_LIMIT   8'h6C
`define FCL_ADDR_REMOTE1_LOCAL_HYST   8'h6D
`define FCL_ADDR_CPU_REMOTE2_HYST     8'h6E
`define FCL_ADDR_TREE_TEST_ENABLE     8'h6F

// Storage indices
`define FCL_REG_COUNT                 12
`define FCL_IDX_MIN_DUTY              0
`define FCL_IDX_START_TEMP            3
`define FCL_IDX_CRIT_LIMIT            6
`define FCL_IDX_HYST_A                9
`define FCL_IDX_HYST_B                10
`define FCL_IDX_TEST_EN               11

// Reset values
`define FCL_RST_MIN_DUTY              8'h80
`define FCL_RST_START_TEMP            8'h5A
`define FCL_RST_CRIT_LIMIT            8'h64
`define FCL_RST_HYST                  8'h44
`define FCL_RST_TEST_EN               8'h00

// Fields and codes
`define FCL_HYST_HI_MSB               7
`define FCL_HYST_HI_LSB               4
`define FCL_HYST_LO_MSB               3
`define FCL_HYST_LO_LSB               0
`define FCL_TEST_EN_BIT               0
`define FCL_CRIT_DISABLE              8'h80
`define FCL_DUTY_FULL                 8'hFF
`define FCL_DUTY_OFF                  8'h00
`define FCL_QUARTER_DEG               12'sh001

`endif

// ---- fcl_pkg.sv ----
package fcl_pkg;

   typedef logic [7:0] fcl_byte_t;
   typedef logic [9:0] fcl_temp_t;

   typedef enum logic [2:0]
   {
      fcl_st_idle = 3'b001,
      fcl_st_run  = 3'b010,
      fcl_st_crit = 3'b100
   } fcl_loop_state_t;

endpackage

// ---- fcl_channel.sv ----
`timescale 1ns/1ps
`include "fcl_map.svh"
module fcl_channel
(
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // Channel settings and temperature
   input  wire fcl_pkg::fcl_temp_t       temp_q,
   input  wire fcl_pkg::fcl_byte_t       start_temperature,
   input  wire fcl_pkg::fcl_byte_t       crit_limit,
   input  wire logic [3:0]               hyst_nibble,
   // Channel status
   output fcl_pkg::fcl_loop_state_t      loop_state,
   output logic                          overtemp_quarter
);
   import fcl_pkg::*;

   fcl_loop_state_t     state_reg;
   fcl_loop_state_t     state_next;
   logic signed [11:0]  t_s;
   logic signed [11:0]  start_s;
   logic signed [11:0]  start_low_s;
   logic signed [11:0]  crit_s;
   logic signed [11:0]  crit_low_s;
   logic                crit_en;

   // Quarter-degree units
   assign t_s         = {2'b00, temp_q};
   assign start_s     = {2'b00, start_temperature, 2'b00};
   assign start_low_s = start_s - {6'h00, hyst_nibble, 2'b00};
   assign crit_s      = {2'b00, crit_limit, 2'b00};
   assign crit_low_s  = crit_s - {6'h00, hyst_nibble, 2'b00};
   assign crit_en     = crit_limit != `FCL_CRIT_DISABLE;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         fcl_st_idle:
         begin
            if (crit_en && t_s > crit_s)
               state_next = fcl_st_crit;
            else if (t_s > start_s)
               state_next = fcl_st_run;
         end
         fcl_st_run:
         begin
            if (crit_en && t_s > crit_s)
               state_next = fcl_st_crit;
            else if (t_s <= start_low_s)
               state_next = fcl_st_idle;
         end
         fcl_st_crit:
         begin
            if (!crit_en || t_s < crit_low_s)
               state_next = fcl_st_run;
         end
         default:
            state_next = fcl_st_idle;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         state_reg <= fcl_st_idle;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         overtemp_quarter <= 1'b0;
      else
         overtemp_quarter <= crit_en && (t_s >= crit_s + `FCL_QUARTER_DEG);
   end

   assign loop_state = state_reg;

endmodule

// ---- fcl_limit_regs.sv ----
`timescale 1ns/1ps
`include "fcl_map.svh"
// Overview of operation
// - Three 8-bit minimum duty registers, one per fan output, reset to half duty.
// - Minimum duty code is linear: 0x00 off, 0x40 quarter, 0xFF full speed.
// - Host writes to minimum duty registers are ignored under automatic fan control.
// - With the lock bit set, every host write to this block is discarded.
// - Start temperature registers for remote 1, local, remote 2, reset to 90 degrees.
// - Above start temperature a fan runs at minimum duty, rising with temperature.
// - Critical limit registers for the three channels, reset to 100 degrees.
// - Any temperature above its critical limit forces all outputs to full duty.
// - A critical limit of 0x80 disables that channel's override.
// - Full duty holds until temperature falls below limit minus hysteresis.
// - Overtemp pin, when an output, goes low a quarter degree past the limit.
// - First hysteresis register: local in low nibble, remote 1 in high nibble.
// - Second hysteresis register: cpu channel low nibble, remote 2 high nibble.
// - Each nibble gives 0 to 15 degrees of hysteresis to its own channel.
// - Below start, fan stays at minimum until start minus hysteresis is reached.
// - Bit 0 of test enable selects tree test mode; clearing it returns to normal.
// - Below start minus hysteresis, a select bit picks 0% or minimum duty.
module fcl_limit_regs
#(
   parameter logic [7:0] DUTY_STEP = 8'h04
)
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr_stb,
   input  wire logic                  reg_rd_stb,
   input  wire fcl_pkg::fcl_byte_t    reg_wdata,
   output fcl_pkg::fcl_byte_t         reg_rdata,
   output logic                       reg_ack,
   // Control inputs
   input  wire logic                  lock_bit,
   input  wire logic                  automatic_fan_control,
   input  wire logic [2:0]            below_start_duty_select,
   input  wire logic                  overtemp_pin_is_output,
   // Measured temperatures
   input  wire fcl_pkg::fcl_temp_t    remote1_temp,
   input  wire fcl_pkg::fcl_temp_t    local_temp,
   input  wire fcl_pkg::fcl_temp_t    remote2_temp,
   // Fan drive duty
   output fcl_pkg::fcl_byte_t         fan_drive_output_1,
   output fcl_pkg::fcl_byte_t         fan_drive_output_2,
   output fcl_pkg::fcl_byte_t         fan_drive_output_3,
   // Status and pins
   output logic                       critical_override,
   output logic                       tree_test_enable_bit,
   output logic [3:0]                 cpu_channel_hyst_nibble,
   output logic                       overtemp_pin_out,
   output logic                       overtemp_pin_oe
);
   import fcl_pkg::*;

   fcl_byte_t           regs_reg [0:`FCL_REG_COUNT-1];
   logic [95:0]         regs_flat;
   fcl_temp_t           temp_q [0:2];
   logic [3:0]          chan_hyst [0:2];
   fcl_loop_state_t     chan_state [0:2];
   logic [2:0]          chan_quarter;
   logic [2:0]          chan_crit;
   fcl_byte_t           duty_reg [0:2];
   logic                in_range;
   logic [3:0]          reg_idx;
   logic                crit_any;

   function automatic fcl_byte_t fcl_reset_value(input int idx);
      fcl_byte_t v;
      if (idx < `FCL_IDX_START_TEMP)
         v = `FCL_RST_MIN_DUTY;
      else if (idx < `FCL_IDX_CRIT_LIMIT)
         v = `FCL_RST_START_TEMP;
      else if (idx < `FCL_IDX_HYST_A)
         v = `FCL_RST_CRIT_LIMIT;
      else if (idx < `FCL_IDX_TEST_EN)
         v = `FCL_RST_HYST;
      else
         v = `FCL_RST_TEST_EN;
      return v;
   endfunction

   // Address decode
   assign in_range = (reg_addr >= `FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY) &&
                     (reg_addr <= `FCL_ADDR_TREE_TEST_ENABLE);
   assign reg_idx  = 4'(reg_addr - `FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY);

   // Register storage
   for (genvar i = 0; i < `FCL_REG_COUNT; i++)
   begin : g_reg
      logic wr_ok;
      assign wr_ok = reg_wr_stb && in_range && (reg_idx == 4'(i)) &&
                     !lock_bit &&
                     !(automatic_fan_control && (i < `FCL_IDX_START_TEMP));
      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
            regs_reg[i] <= fcl_reset_value(i);
         else if (wr_ok)
            regs_reg[i] <= reg_wdata;
      end
      assign regs_flat[i*8 +: 8] = regs_reg[i];
   end

   // Bus answer
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         reg_ack <= 1'b0;
      else
         reg_ack <= reg_wr_stb || reg_rd_stb;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd_stb)
         reg_rdata <= in_range ? regs_reg[reg_idx] : 8'h00;
   end

   // Hysteresis nibbles
   assign chan_hyst[0] =
      regs_reg[`FCL_IDX_HYST_A][`FCL_HYST_HI_MSB:`FCL_HYST_HI_LSB];
   assign chan_hyst[1] =
      regs_reg[`FCL_IDX_HYST_A][`FCL_HYST_LO_MSB:`FCL_HYST_LO_LSB];
   assign chan_hyst[2] =
      regs_reg[`FCL_IDX_HYST_B][`FCL_HYST_HI_MSB:`FCL_HYST_HI_LSB];
   assign cpu_channel_hyst_nibble =
      regs_reg[`FCL_IDX_HYST_B][`FCL_HYST_LO_MSB:`FCL_HYST_LO_LSB];

   assign temp_q[0] = remote1_temp;
   assign temp_q[1] = local_temp;
   assign temp_q[2] = remote2_temp;

   assign crit_any = |chan_crit;

   // Per channel loop and fan duty
   for (genvar c = 0; c < 3; c++)
   begin : g_chan
      fcl_byte_t    min_duty;
      fcl_byte_t    start_t;
      fcl_byte_t    duty_next;
      logic [15:0]  rise;
      logic [15:0]  ramp;

      assign min_duty = regs_reg[`FCL_IDX_MIN_DUTY + c];
      assign start_t  = regs_reg[`FCL_IDX_START_TEMP + c];

      fcl_channel u_chan
      (
         .ref_clk           (ref_clk),
         .rst               (rst),
         .temp_q            (temp_q[c]),
         .start_temperature (start_t),
         .crit_limit        (regs_reg[`FCL_IDX_CRIT_LIMIT + c]),
         .hyst_nibble       (chan_hyst[c]),
         .loop_state        (chan_state[c]),
         .overtemp_quarter  (chan_quarter[c])
      );

      assign chan_crit[c] = chan_state[c] == fcl_st_crit;

      always_comb
      begin
         rise = 16'h0000;
         if (temp_q[c][9:2] > start_t)
            rise = {8'h00, temp_q[c][9:2]} - {8'h00, start_t};
         ramp = 16'({8'h00, min_duty} + 24'(rise * DUTY_STEP));
         if (crit_any)
            duty_next = `FCL_DUTY_FULL;
         else if (!automatic_fan_control)
            duty_next = min_duty;
         else if (chan_state[c] == fcl_st_run)
            duty_next = (ramp > 16'h00FF) ? `FCL_DUTY_FULL : ramp[7:0];
         else if (below_start_duty_select[c])
            duty_next = min_duty;
         else
            duty_next = `FCL_DUTY_OFF;
      end

      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
            duty_reg[c] <= `FCL_DUTY_FULL;
         else
            duty_reg[c] <= duty_next;
      end

      // Limit disabled for two cycles running never overrides
      property p_crit_disabled;
         @(posedge ref_clk) disable iff (rst)
         (regs_reg[`FCL_IDX_CRIT_LIMIT + c] == `FCL_CRIT_DISABLE) [*2] |-> !chan_crit[c];
      endproperty
      a_crit_disabled: assert property (p_crit_disabled)
         else $error("disabled critical limit still overriding");
   end

   assign fan_drive_output_1 = duty_reg[0];
   assign fan_drive_output_2 = duty_reg[1];
   assign fan_drive_output_3 = duty_reg[2];

   // Status outputs
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         critical_override <= 1'b0;
      else
         critical_override <= crit_any;
   end

   assign tree_test_enable_bit = regs_reg[`FCL_IDX_TEST_EN][`FCL_TEST_EN_BIT];

   // Open-drain overtemp pin, driven low only
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         overtemp_pin_oe <= 1'b0;
      else
         overtemp_pin_oe <= overtemp_pin_is_output && (|chan_quarter);
   end

   assign overtemp_pin_out = 1'b0;

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_write_to(logic [7:0] a);
      reg_wr_stb && (reg_addr == a);
   endsequence

   sequence s_unlocked_write_to(logic [7:0] a);
      s_write_to(a) ##0 !lock_bit;
   endsequence

   property p_ack_write;
      reg_wr_stb |=> reg_ack;
   endproperty
   a_ack_write: assert property (p_ack_write)
      else $error("write not acknowledged");

   property p_lock_freeze;
      (reg_wr_stb && lock_bit) |=> $stable(regs_flat);
   endproperty
   a_lock_freeze: assert property (p_lock_freeze)
      else $error("locked write changed a register");

   property p_min_read_only;
      (reg_wr_stb && automatic_fan_control &&
       (reg_addr <= `FCL_ADDR_PWM3_MIN_DUTY)) |=> $stable(regs_flat[23:0]);
   endproperty
   a_min_read_only: assert property (p_min_read_only)
      else $error("minimum duty written under automatic control");

   property p_crit_full;
      crit_any |=> (fan_drive_output_1 == `FCL_DUTY_FULL) &&
                   (fan_drive_output_2 == `FCL_DUTY_FULL) &&
                   (fan_drive_output_3 == `FCL_DUTY_FULL) && critical_override;
   endproperty
   a_crit_full: assert property (p_crit_full)
      else $error("critical override did not force full duty");

   sequence s_auto_below(int c);
      automatic_fan_control && !crit_any && (chan_state[c] == fcl_st_idle);
   endsequence

   property p_off_below;
      (s_auto_below(0) ##0 !below_start_duty_select[0]) |=>
         fan_drive_output_1 == `FCL_DUTY_OFF;
   endproperty
   a_off_below: assert property (p_off_below)
      else $error("fan not off below start minus hysteresis");

   property p_min_below;
      (s_auto_below(1) ##0 below_start_duty_select[1]) |=>
         fan_drive_output_2 == $past(regs_reg[`FCL_IDX_MIN_DUTY + 1]);
   endproperty
   a_min_below: assert property (p_min_below)
      else $error("fan not at minimum duty when selected");

   property p_hold_min;
      (automatic_fan_control && !crit_any && (chan_state[0] == fcl_st_run) &&
       (temp_q[0][9:2] <= regs_reg[`FCL_IDX_START_TEMP])) |=>
         fan_drive_output_1 == $past(regs_reg[`FCL_IDX_MIN_DUTY]);
   endproperty
   a_hold_min: assert property (p_hold_min)
      else $error("fan left minimum duty inside hysteresis band");

   property p_run_ramp;
      (automatic_fan_control && !crit_any && (chan_state[2] == fcl_st_run)) |=>
         fan_drive_output_3 >= $past(regs_reg[`FCL_IDX_MIN_DUTY + 2]);
   endproperty
   a_run_ramp: assert property (p_run_ramp)
      else $error("running fan below minimum duty");

   property p_test_mode;
      s_unlocked_write_to(`FCL_ADDR_TREE_TEST_ENABLE) |=>
         tree_test_enable_bit == $past(reg_wdata[`FCL_TEST_EN_BIT]);
   endproperty
   a_test_mode: assert property (p_test_mode)
      else $error("test enable bit did not follow write");

   property p_cpu_nibble;
      s_unlocked_write_to(`FCL_ADDR_CPU_REMOTE2_HYST) |=>
         cpu_channel_hyst_nibble == $past(reg_wdata[3:0]);
   endproperty
   a_cpu_nibble: assert property (p_cpu_nibble)
      else $error("cpu hysteresis nibble did not follow write");

   property p_overtemp_pin;
      ((|chan_quarter) && overtemp_pin_is_output) |=> overtemp_pin_oe && !overtemp_pin_out;
   endproperty
   a_overtemp_pin: assert property (p_overtemp_pin)
      else $error("overtemp pin not pulled low");

   property p_manual_min;
      (!automatic_fan_control && !crit_any) |=>
         fan_drive_output_2 == $past(regs_reg[`FCL_IDX_MIN_DUTY + 1]);
   endproperty
   a_manual_min: assert property (p_manual_min)
      else $error("manual mode fan not at minimum duty code");

   property p_min_duty_write;
      (s_unlocked_write_to(`FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY) ##0 !automatic_fan_control) |=>
         regs_reg[`FCL_IDX_MIN_DUTY] == $past(reg_wdata);
   endproperty
   a_min_duty_write: assert property (p_min_duty_write)
      else $error("minimum duty write did not land");

   property p_hyst_nibbles;
      s_unlocked_write_to(`FCL_ADDR_REMOTE1_LOCAL_HYST) |=>
         (chan_hyst[0] == $past(reg_wdata[7:4])) &&
         (chan_hyst[1] == $past(reg_wdata[3:0]));
   endproperty
   a_hyst_nibbles: assert property (p_hyst_nibbles)
      else $error("hysteresis nibbles did not follow write");

   property p_lock_ack;
      (reg_wr_stb && lock_bit) |=> reg_ack;
   endproperty
   a_lock_ack: assert property (p_lock_ack)
      else $error("locked write not acknowledged");

endmodule

// ---- fcl_host_model.sv ----
`timescale 1ns/1ps
`include "fcl_map.svh"
module fcl_host_model
(
   // Clock
   input  wire logic               ref_clk,
   // Register port requests
   output logic [7:0]              reg_addr,
   output logic                    reg_wr_stb,
   output logic                    reg_rd_stb,
   output fcl_pkg::fcl_byte_t      reg_wdata,
   // Register port answers
   input  wire fcl_pkg::fcl_byte_t reg_rdata,
   input  wire logic               reg_ack
);
   import fcl_pkg::*;

   initial
   begin
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      reg_wr_stb = 1'b0;
      reg_rd_stb = 1'b0;
   end

   // One request: strobe for one edge, wait for the acknowledge
   task automatic access(input logic wr, input logic [7:0] addr, input fcl_byte_t data,
                         output fcl_byte_t rdata, output logic ok);
      int        n;
      fcl_byte_t d;
      d = data;
      // Only the test mode bit of the test enable register is ever written
      if (addr == `FCL_ADDR_TREE_TEST_ENABLE)
         d = {7'h00, data[0]};
      @(negedge ref_clk);
      reg_addr   = addr;
      reg_wdata  = d;
      reg_wr_stb = wr;
      reg_rd_stb = !wr;
      @(negedge ref_clk);
      reg_wr_stb = 1'b0;
      reg_rd_stb = 1'b0;
      n = 0;
      while (reg_ack !== 1'b1 && n < 4)
      begin
         @(negedge ref_clk);
         n++;
      end
      ok    = (reg_ack === 1'b1);
      rdata = reg_rdata;
      @(negedge ref_clk);
      // Released lines show no stale value
      reg_addr  = ~addr;
      reg_wdata = ~d;
   endtask
endmodule

// ---- tb_fcl_limit_regs.sv ----
`timescale 1ns/1ps
`include "fcl_map.svh"
module tb_fcl_limit_regs;
   import fcl_pkg::*;

   localparam logic [7:0] STEP = 8'h04;
   localparam logic [7:0] RST_TAB [12] = '{`FCL_RST_MIN_DUTY, `FCL_RST_MIN_DUTY,
      `FCL_RST_MIN_DUTY, `FCL_RST_START_TEMP, `FCL_RST_START_TEMP, `FCL_RST_START_TEMP,
      `FCL_RST_CRIT_LIMIT, `FCL_RST_CRIT_LIMIT, `FCL_RST_CRIT_LIMIT, `FCL_RST_HYST,
      `FCL_RST_HYST, `FCL_RST_TEST_EN};
   localparam logic [7:0] WR_TAB [12] = '{8'h11, 8'h22, 8'h33, 8'h40, 8'h41, 8'h42,
      8'h70, 8'h71, 8'h72, 8'h5A, 8'h97, 8'h01};

   logic               ref_clk, rst, reg_wr_stb, reg_rd_stb, reg_ack;
   logic [7:0]         reg_addr;
   fcl_byte_t          reg_wdata, reg_rdata, fan1, fan2, fan3;
   logic               lock_bit, automatic_fan_control, overtemp_pin_is_output;
   logic [2:0]         below_start_duty_select;
   fcl_temp_t          remote1_temp, local_temp, remote2_temp;
   logic               critical_override, tree_bit, overtemp_pin_out, overtemp_pin_oe;
   logic [3:0]         cpu_nib;
   int                 err_count, cmp_count, i;

   fcl_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
      .reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack));

   fcl_limit_regs #(.DUTY_STEP(STEP)) dut (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .lock_bit(lock_bit), .automatic_fan_control(automatic_fan_control),
      .below_start_duty_select(below_start_duty_select),
      .overtemp_pin_is_output(overtemp_pin_is_output), .remote1_temp(remote1_temp),
      .local_temp(local_temp), .remote2_temp(remote2_temp), .fan_drive_output_1(fan1),
      .fan_drive_output_2(fan2), .fan_drive_output_3(fan3),
      .critical_override(critical_override), .tree_test_enable_bit(tree_bit),
      .cpu_channel_hyst_nibble(cpu_nib), .overtemp_pin_out(overtemp_pin_out),
      .overtemp_pin_oe(overtemp_pin_oe));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic fcl_temp_t deg(input int d);
      return fcl_temp_t'(d * 4);
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      fcl_byte_t r;
      logic      ok;
      host.access(1'b1, a, d, r, ok);
      chk({7'h00, ok}, 8'h01);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      fcl_byte_t r;
      logic      ok;
      host.access(1'b0, a, 8'h00, r, ok);
      chk({7'h00, ok}, 8'h01);
      chk(r, exp);
   endtask

   task automatic settle_fans(input logic [7:0] e1, input logic [7:0] e2,
                              input logic [7:0] e3);
      repeat (3) @(negedge ref_clk);
      chk(fan1, e1);
      chk(fan2, e2);
      chk(fan3, e3);
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      #100us;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      err_count = 0;
      cmp_count = 0;
      rst = 1'b1;
      lock_bit = 1'b0;
      automatic_fan_control = 1'b0;
      below_start_duty_select = 3'b000;
      overtemp_pin_is_output = 1'b1;
      remote1_temp = deg(20);
      local_temp = deg(20);
      remote2_temp = deg(20);
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      // Reset values, then write and read back every register
      for (i = 0; i < 12; i++)
         rd_chk(8'h64 + 8'(i), RST_TAB[i]);
      chk({4'h0, cpu_nib}, 8'h04);
      chk({7'h00, tree_bit}, 8'h00);
      for (i = 0; i < 12; i++)
         wr(8'h64 + 8'(i), WR_TAB[i]);
      for (i = 0; i < 12; i++)
         rd_chk(8'h64 + 8'(i), WR_TAB[i]);
      chk({4'h0, cpu_nib}, 8'h07);
      chk({7'h00, tree_bit}, 8'h01);
      wr(`FCL_ADDR_TREE_TEST_ENABLE, 8'h00);
      chk({7'h00, tree_bit}, 8'h00);
      wr(8'h70, 8'h5A);
      rd_chk(8'h70, 8'h00);
      // Manual mode drives the minimum duty codes
      foreach (WR_TAB[j])
         if (j < 3)
         begin
            wr(`FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY, 8'h00);
            settle_fans(8'h00, 8'h22, 8'h33);
         end
      wr(`FCL_ADDR_PWM2_MIN_DUTY, 8'h40);
      wr(`FCL_ADDR_PWM3_MIN_DUTY, 8'hFF);
      settle_fans(8'h00, 8'h40, 8'hFF);
      // Second reset in mid-run
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(fan1, `FCL_DUTY_FULL);
      rst = 1'b0;
      // Automatic mode
      automatic_fan_control = 1'b1;
      wr(`FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY, 8'h20);
      rd_chk(`FCL_ADDR_FAN_DRIVE_OUTPUT_1_MIN_DUTY, 8'h80);
      below_start_duty_select = 3'b110;
      settle_fans(8'h00, 8'h80, 8'h80);
      below_start_duty_select = 3'b000;
      remote1_temp = deg(93);
      settle_fans(8'h80 + 3 * STEP, 8'h00, 8'h00);
      remote1_temp = deg(89);
      settle_fans(8'h80, 8'h00, 8'h00);
      remote1_temp = deg(86);
      settle_fans(8'h00, 8'h00, 8'h00);
      // Independent hysteresis nibbles: remote 1 gets 8, local 4
      wr(`FCL_ADDR_REMOTE1_LOCAL_HYST, 8'h84);
      remote1_temp = deg(93);
      settle_fans(8'h80 + 3 * STEP, 8'h00, 8'h00);
      remote1_temp = deg(86);
      settle_fans(8'h80, 8'h00, 8'h00);
      remote1_temp = deg(82);
      settle_fans(8'h00, 8'h00, 8'h00);
      // Critical override with hysteresis and pin
      remote1_temp = deg(100);
      settle_fans(8'h80 + 10 * STEP, 8'h00, 8'h00);
      chk({7'h00, overtemp_pin_oe}, 8'h00);
      remote1_temp = deg(100) + 10'd1;
      settle_fans(8'hFF, 8'hFF, 8'hFF);
      chk({7'h00, critical_override}, 8'h01);
      chk({7'h00, overtemp_pin_oe}, 8'h01);
      chk({7'h00, overtemp_pin_out}, 8'h00);
      remote1_temp = deg(93);
      settle_fans(8'hFF, 8'hFF, 8'hFF);
      remote1_temp = deg(91);
      settle_fans(8'h80 + STEP, 8'h00, 8'h00);
      chk({7'h00, critical_override}, 8'h00);
      overtemp_pin_is_output = 1'b0;
      local_temp = deg(101);
      settle_fans(8'hFF, 8'hFF, 8'hFF);
      chk({7'h00, overtemp_pin_oe}, 8'h00);
      wr(`FCL_ADDR_LOCAL_CRIT_LIMIT, `FCL_CRIT_DISABLE);
      settle_fans(8'h80 + STEP, 8'h80 + 11 * STEP, 8'h00);
      chk({7'h00, critical_override}, 8'h00);
      remote2_temp = deg(95);
      settle_fans(8'h80 + STEP, 8'h80 + 11 * STEP, 8'h80 + 5 * STEP);
      // Global lock
      lock_bit = 1'b1;
      wr(`FCL_ADDR_REMOTE1_START_TEMP, 8'h33);
      rd_chk(`FCL_ADDR_REMOTE1_START_TEMP, 8'h5A);
      wr(`FCL_ADDR_REMOTE1_LOCAL_HYST, 8'h55);
      rd_chk(`FCL_ADDR_REMOTE1_LOCAL_HYST, 8'h84);
      wr(`FCL_ADDR_TREE_TEST_ENABLE, 8'h01);
      rd_chk(`FCL_ADDR_TREE_TEST_ENABLE, 8'h00);
      chk({7'h00, tree_bit}, 8'h00);
      lock_bit = 1'b0;
      wr(`FCL_ADDR_REMOTE1_START_TEMP, 8'h33);
      rd_chk(`FCL_ADDR_REMOTE1_START_TEMP, 8'h33);
      tally_and_finish();
   end
endmodule
